// [verilog/socket_manager_status_register.sv]
// Socket manager progress tracking and its read-only status word
`timescale 1ns/1ps
`include "sm_status_defines.svh"

// Operation
// RULE1: Status reads at the command address; writes there go to the command register.
// RULE2: Bits 31:24 hold bitstream ident for one family, zero for the others.
// RULE3: Bits 23:8 hold the ident of the module the status describes.
// RULE4: Bit 7 is high exactly while the manager is shut down.
// RULE5: Bits 6:3 carry the failure code; 0000 none, 1111 unknown.
// RULE6: Code 0001 when a zero-byte bitstream is requested.
// RULE7: Code 0010 when the configuration access port reports an error.
// RULE8: Code 0011 when port access is withdrawn; only two families.
// RULE9: Code 0100 when fetching from library memory fails.
// RULE10: Port plus fetch gives 0101; lost plus fetch gives 0110.
// RULE11: Active progress 000 is empty socket, 111 is module loaded.
// RULE12: Active progress 001 hardware shutdown step, 010 software shutdown step.
// RULE13: Active progress 011 loads clearing bitstream; one family only.
// RULE14: Active progress 100 loading, 101 software start-up, 110 module reset.
// RULE15: When shut down, bits 2:0 follow the quiesce acknowledge input.
// RULE16: Status sits in general bank at select zero, read over register port.
// RULE17: Fields track the steps; reading never alters or clears anything.
module socket_manager_status_register
  import sm_status_pkg::*;
#(
  parameter logic [1:0] device_family = `FAMILY_B
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  // Register port of the general bank
  input  wire logic [1:0]  reg_bank,
  input  wire logic [7:0]  reg_sel,
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,
  output logic             reg_rack,
  // Command register feed
  output logic             cmd_valid,
  output logic [31:0]      cmd_word,
  // Trigger carrying the module to load
  input  wire logic        trigger_valid,
  input  wire logic [15:0] trigger_module_ident,
  input  wire logic [7:0]  trigger_bitstream_ident,
  input  wire logic [31:0] trigger_bitstream_size,
  input  wire logic        opt_hw_shutdown,
  input  wire logic        opt_sw_shutdown,
  input  wire logic        opt_sw_startup,
  input  wire logic        opt_mod_reset,
  // Step completion from the surrounding controller
  input  wire logic        hw_shutdown_done,
  input  wire logic        sw_shutdown_done,
  input  wire logic        load_done,
  input  wire logic        sw_startup_done,
  input  wire logic        mod_reset_done,
  // Failure events during a transfer, and the quiesce acknowledge
  input  wire logic        config_access_port_error,
  input  wire logic        config_access_lost,
  input  wire logic        fetch_error,
  input  wire logic        module_quiesce_ack,
  // Fetch path request and the status word
  output logic             fetch_start,
  output logic             fetch_clearing,
  output logic [31:0]      status
);

  //////////////////////////////////////////////////////////////////////////////
  // Internal signals
  manager_state_t state;
  manager_state_t next_state;
  logic [15:0]    module_ident;
  logic [7:0]     bitstream_ident;
  logic [31:0]    bitstream_size;
  logic           keep_sw_startup;
  logic           keep_mod_reset;
  logic           keep_sw_shutdown;
  logic           keep_clear;
  logic           status_hit;
  logic           cmd_hit;
  logic [7:0]     cmd_code;
  logic           cmd_shutdown;
  logic           cmd_restart_bare;
  logic           cmd_restart_status;
  logic           trigger_take;
  logic           loading;
  logic           flags_clear;
  logic           bad_config;
  logic           port_error;
  logic           access_lost;
  logic           fetch_failed;
  logic           any_failure;
  logic [3:0]     load_fail_code;
  logic [2:0]     step_code;
  logic [31:0]    next_status;
  logic           clear_supported;
  logic           lost_possible;

  assign clear_supported = (device_family == `FAMILY_B);
  assign lost_possible   = (device_family == `FAMILY_B) || (device_family == `FAMILY_C);

  //////////////////////////////////////////////////////////////////////////////
  // Address decode and commands
  assign status_hit = (reg_bank == `BANK_GENERAL) && (reg_sel == `SEL_STATUS);      // [RULE16]
  assign cmd_hit    = status_hit && reg_wr;                                          // [RULE1]
  assign cmd_code   = reg_wdata[`CMD_CODE_HI:`CMD_CODE_LO];
  assign cmd_shutdown       = cmd_hit && (cmd_code == `CMD_SHUTDOWN);
  assign cmd_restart_bare   = cmd_hit && (cmd_code == `CMD_RESTART_BARE);
  assign cmd_restart_status = cmd_hit && (cmd_code == `CMD_RESTART_STATUS);

  assign trigger_take = trigger_valid && ((state == st_empty) || (state == st_full));
  assign loading      = (state == st_load) || (state == st_clear);
  assign flags_clear  = trigger_take ||
                        ((state == st_shutdown) && (cmd_restart_bare || cmd_restart_status));

  // Write strobes pass straight to the command register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_valid <= 1'b0;
      cmd_word  <= `STATUS_RESET;
    end else begin
      cmd_valid <= cmd_hit;                                                          // [RULE1]
      if (cmd_hit) begin
        cmd_word <= reg_wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Failure capture
  event_latch u_bad_config (
    .clk    (clk),
    .resetn (resetn),
    .set    (state == st_load && bitstream_size == `BS_SIZE_ZERO),                  // [RULE6]
    .clear  (flags_clear),
    .flag   (bad_config)
  );

  event_latch u_port_error (
    .clk    (clk),
    .resetn (resetn),
    .set    (loading && config_access_port_error),                                  // [RULE7]
    .clear  (flags_clear),
    .flag   (port_error)
  );

  event_latch u_access_lost (
    .clk    (clk),
    .resetn (resetn),
    .set    (loading && config_access_lost && lost_possible),                       // [RULE8]
    .clear  (flags_clear),
    .flag   (access_lost)
  );

  event_latch u_fetch_error (
    .clk    (clk),
    .resetn (resetn),
    .set    (loading && fetch_error),                                                // [RULE9]
    .clear  (flags_clear),
    .flag   (fetch_failed)
  );

  fail_code_encoder u_encoder (
    .bad_config     (bad_config),
    .port_error     (port_error),
    .access_lost    (access_lost),
    .fetch_error    (fetch_failed),
    .load_fail_code (load_fail_code)                                                 // [RULE10]
  );

  assign any_failure = bad_config || port_error || access_lost || fetch_failed;

  //////////////////////////////////////////////////////////////////////////////
  // Trigger capture
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      module_ident     <= 16'h0000;
      bitstream_ident  <= 8'h00;
      bitstream_size   <= `BS_SIZE_ZERO;
      keep_sw_startup  <= 1'b0;
      keep_mod_reset   <= 1'b0;
      keep_sw_shutdown <= 1'b0;
      keep_clear       <= 1'b0;
    end else if (trigger_take) begin
      module_ident     <= trigger_module_ident;                                      // [RULE3]
      bitstream_ident  <= trigger_bitstream_ident;
      bitstream_size   <= trigger_bitstream_size;
      keep_sw_startup  <= opt_sw_startup;
      keep_mod_reset   <= opt_mod_reset;
      keep_sw_shutdown <= opt_sw_shutdown;
      keep_clear       <= clear_supported && (state == st_full);                    // [RULE13]
    end else if ((state == st_shutdown) && cmd_restart_status) begin
      module_ident     <= reg_wdata[`CMD_HALF_HI:`CMD_HALF_LO];
      bitstream_ident  <= reg_wdata[`CMD_BYTE_HI:`CMD_BYTE_LO];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Step sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      st_empty, st_full: begin
        if (trigger_take && state == st_full && opt_hw_shutdown) begin
          next_state = st_hw_shut;
        end else if (trigger_take && state == st_full && opt_sw_shutdown) begin
          next_state = st_sw_shut;
        end else if (trigger_take && state == st_full && clear_supported) begin
          next_state = st_clear;
        end else if (trigger_take) begin
          next_state = st_load;
        end
      end
      st_hw_shut: begin
        if (hw_shutdown_done) begin
          next_state = keep_sw_shutdown ? st_sw_shut : (keep_clear ? st_clear : st_load);
        end
      end
      st_sw_shut: begin
        if (sw_shutdown_done) begin
          next_state = keep_clear ? st_clear : st_load;
        end
      end
      st_clear: begin
        if (load_done) begin
          next_state = any_failure ? st_empty : st_load;
        end
      end
      st_load: begin
        if (bad_config) begin
          next_state = st_empty;
        end else if (load_done) begin
          if (any_failure) begin
            next_state = st_empty;
          end else if (keep_sw_startup) begin
            next_state = st_sw_start;
          end else if (keep_mod_reset) begin
            next_state = st_mod_reset;
          end else begin
            next_state = st_full;
          end
        end
      end
      st_sw_start: begin
        if (sw_startup_done) begin
          next_state = keep_mod_reset ? st_mod_reset : st_full;
        end
      end
      st_mod_reset: begin
        if (mod_reset_done) begin
          next_state = st_full;
        end
      end
      st_shutdown: begin
        if (cmd_restart_bare) begin
          next_state = st_empty;
        end else if (cmd_restart_status) begin
          next_state = st_full;
        end
      end
      default: next_state = st_empty;
    endcase
    if (cmd_shutdown) begin
      next_state = st_shutdown;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= st_empty;
    end else begin
      state <= next_state;                                                           // [RULE17]
    end
  end

  // Fetch request pulses on entry to a load or clearing step
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fetch_start    <= 1'b0;
      fetch_clearing <= 1'b0;
    end else begin
      fetch_start    <= (next_state != state) &&
                        ((next_state == st_load) || (next_state == st_clear));
      fetch_clearing <= (next_state == st_clear);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status word
  always_comb begin
    step_code = `STEP_EMPTY;
    unique case (state)
      st_empty:     step_code = `STEP_EMPTY;                                         // [RULE11]
      st_hw_shut:   step_code = `STEP_HW_SHUT;                                       // [RULE12]
      st_sw_shut:   step_code = `STEP_SW_SHUT;                                       // [RULE12]
      st_clear:     step_code = `STEP_CLEAR;                                         // [RULE13]
      st_load:      step_code = `STEP_LOAD;                                          // [RULE14]
      st_sw_start:  step_code = `STEP_SW_START;                                      // [RULE14]
      st_mod_reset: step_code = `STEP_MOD_RESET;                                     // [RULE14]
      st_full:      step_code = `STEP_FULL;                                          // [RULE11]
      st_shutdown:  step_code = module_quiesce_ack ? `STEP_ACK_HIGH : `STEP_ACK_LOW; // [RULE15]
      default:      step_code = `STEP_EMPTY;
    endcase
  end

  always_comb begin
    next_status = `STATUS_RESET;
    next_status[`BSID_HI:`BSID_LO]   = clear_supported ? bitstream_ident
                                                       : `BSID_RESERVED;             // [RULE2]
    next_status[`MODID_HI:`MODID_LO] = module_ident;                                 // [RULE3]
    next_status[`SHUT_BIT]           = (state == st_shutdown);                       // [RULE4]
    next_status[`CODE_HI:`CODE_LO]   = load_fail_code;                               // [RULE5]
    next_status[`STEP_HI:`STEP_LO]   = step_code;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status <= `STATUS_RESET;
    end else begin
      status <= next_status;                                                         // [RULE17]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port; reads have no side effect
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= `STATUS_RESET;
      reg_rack  <= 1'b0;
    end else begin
      reg_rack <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= status_hit ? status : `STATUS_RESET;                            // [RULE1]
      end
    end
  end

endmodule // socket_manager_status_register

// [verilog/sm_status_defines.svh]
// Constants for the socket manager status word and its control logic
`ifndef SM_STATUS_DEFINES_SVH
`define SM_STATUS_DEFINES_SVH

// Register addressing inside one socket manager
`define BANK_GENERAL        2'h0
`define SEL_STATUS          8'h00

// Status word layout
`define BSID_HI             31
`define BSID_LO             24
`define MODID_HI            23
`define MODID_LO            8
`define SHUT_BIT            7
`define CODE_HI             6
`define CODE_LO             3
`define STEP_HI             2
`define STEP_LO             0
`define BSID_RESERVED       8'h00
`define STATUS_RESET        32'h0000_0000

// Load failure codes
`define FAIL_NONE           4'h0
`define FAIL_BAD_CONFIG     4'h1
`define FAIL_PORT           4'h2
`define FAIL_LOST           4'h3
`define FAIL_FETCH          4'h4
`define FAIL_PORT_FETCH     4'h5
`define FAIL_LOST_FETCH     4'h6
`define FAIL_UNKNOWN        4'hf

// Progress codes while active
`define STEP_EMPTY          3'h0
`define STEP_HW_SHUT        3'h1
`define STEP_SW_SHUT        3'h2
`define STEP_CLEAR          3'h3
`define STEP_LOAD           3'h4
`define STEP_SW_START       3'h5
`define STEP_MOD_RESET      3'h6
`define STEP_FULL           3'h7
// Progress codes while shut down
`define STEP_ACK_HIGH       3'h1
`define STEP_ACK_LOW        3'h0

// Managed device families
`define FAMILY_A            2'h0
`define FAMILY_B            2'h1
`define FAMILY_C            2'h2

// Command codes
`define CMD_SHUTDOWN        8'h00
`define CMD_RESTART_BARE    8'h01
`define CMD_RESTART_STATUS  8'h02
`define CMD_CODE_HI         7
`define CMD_CODE_LO         0
`define CMD_BYTE_HI         15
`define CMD_BYTE_LO         8
`define CMD_HALF_HI         31
`define CMD_HALF_LO         16

`define BS_SIZE_ZERO        32'h0000_0000

`endif

// [verilog/sm_status_pkg.sv]
// Types for the socket manager status logic
package sm_status_pkg;

  typedef enum logic [8:0] {
    st_empty     = 9'h001,
    st_hw_shut   = 9'h002,
    st_sw_shut   = 9'h004,
    st_clear     = 9'h008,
    st_load      = 9'h010,
    st_sw_start  = 9'h020,
    st_mod_reset = 9'h040,
    st_full      = 9'h080,
    st_shutdown  = 9'h100
  } manager_state_t;

endpackage

// [verilog/event_latch.sv]
// Sticky event flag where a set beats a simultaneous clear
`timescale 1ns/1ps

module event_latch (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic set,
  input  wire logic clear,
  output logic      flag
);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end

endmodule // event_latch

// [verilog/fail_code_encoder.sv]
// Maps the captured failure flags onto the four-bit load failure code
`timescale 1ns/1ps
`include "sm_status_defines.svh"

module fail_code_encoder (
  input  wire logic       bad_config,
  input  wire logic       port_error,
  input  wire logic       access_lost,
  input  wire logic       fetch_error,
  output logic [3:0]      load_fail_code
);

  always_comb begin
    unique case ({bad_config, port_error, access_lost, fetch_error})
      4'h0:    load_fail_code = `FAIL_NONE;
      4'h8:    load_fail_code = `FAIL_BAD_CONFIG;
      4'h4:    load_fail_code = `FAIL_PORT;
      4'h2:    load_fail_code = `FAIL_LOST;
      4'h1:    load_fail_code = `FAIL_FETCH;
      4'h5:    load_fail_code = `FAIL_PORT_FETCH;
      4'h3:    load_fail_code = `FAIL_LOST_FETCH;
      default: load_fail_code = `FAIL_UNKNOWN;
    endcase
  end

endmodule // fail_code_encoder

// [verification/sm_status_monitor.sv]
// Concurrent checks on the socket manager status register ports
`timescale 1ns/1ps

module sm_status_monitor (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [1:0]  reg_bank,
  input wire logic [7:0]  reg_sel,
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_rack,
  input wire logic        cmd_valid,
  input wire logic [31:0] cmd_word,
  input wire logic        module_quiesce_ack,
  input wire logic [31:0] status
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  logic hit;
  assign hit = (reg_bank == 2'h0) && (reg_sel == 8'h00);

  a_read_answer: assert property (reg_rd |=> reg_rack)
    else $error("read answer missing");
  a_rack_alone: assert property (!reg_rd |=> !reg_rack)
    else $error("read answer without read");
  a_read_data: assert property (reg_rd && hit |=> reg_rdata == $past(status))
    else $error("read data differs from status word");
  a_unmapped_zero: assert property (reg_rd && !hit |=> reg_rdata == 32'h0000_0000)
    else $error("read of other select not zero");
  a_cmd_pulse: assert property (reg_wr && hit |=> cmd_valid && cmd_word == $past(reg_wdata))
    else $error("command write not passed on");
  a_cmd_quiet: assert property (!(reg_wr && hit) |=> !cmd_valid)
    else $error("command pulse without write");
  a_shut_mirror: assert property (status[7] && $past(status[7]) |->
    status[2:0] == {2'b00, $past(module_quiesce_ack)})
    else $error("shutdown progress does not follow acknowledge");
  a_code_legal: assert property (status[6:3] inside {[4'h0:4'h6], 4'hf})
    else $error("failure code outside defined set");
  a_shut_entry: assert property ($rose(status[7]) |-> $past(cmd_valid) && cmd_word[7:0] == 8'h00)
    else $error("shutdown flag rose without shutdown command");
  a_restart_clean: assert property ($fell(status[7]) |-> $past(cmd_valid) && status[6:3] == 4'h0)
    else $error("restart left failure code or had no command");
endmodule // sm_status_monitor

bind socket_manager_status_register sm_status_monitor u_monitor (
  .clk(clk), .resetn(resetn), .reg_bank(reg_bank), .reg_sel(reg_sel), .reg_rd(reg_rd),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rack(reg_rack),
  .cmd_valid(cmd_valid), .cmd_word(cmd_word), .module_quiesce_ack(module_quiesce_ack),
  .status(status)
);

// [verification/tb.sv]
// Self-checking bench for the socket manager status register
`timescale 1ns/1ps
`include "sm_status_defines.svh"

module tb;
  logic        clk;
  logic        resetn;
  logic [1:0]  reg_bank;
  logic [7:0]  reg_sel;
  logic        reg_rd;
  logic        reg_wr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        reg_rack;
  logic        cmd_valid;
  logic [31:0] cmd_word;
  logic        trigger_valid;
  logic [15:0] trig_mod;
  logic [7:0]  trig_bs;
  logic [31:0] trig_size;
  logic [3:0]  opts;
  logic [4:0]  dn;
  logic [2:0]  ev;
  logic        ack;
  logic [31:0] status;
  logic        fetch_start;
  logic        fetch_clearing;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] cmd_q[$];
  logic        fs_q[$];
  logic [15:0] cur_mod;
  logic [7:0]  cur_bs;
  logic [15:0] new_mod;
  logic [7:0]  new_bs;
  int          n_errors;
  int          comparisons;
  int          cycles;
  logic [2:0]  ev_tab[6]   = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3};
  logic [3:0]  code_tab[6] = '{`FAIL_PORT, `FAIL_LOST, `FAIL_FETCH, `FAIL_PORT_FETCH,
                               `FAIL_LOST_FETCH, `FAIL_UNKNOWN};
  int          done_tab[6] = '{0, 1, 2, 2, 3, 4};

  socket_manager_status_register #(.device_family(`FAMILY_B)) u_dut (
    .clk(clk), .resetn(resetn), .reg_bank(reg_bank), .reg_sel(reg_sel), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rack(reg_rack),
    .cmd_valid(cmd_valid), .cmd_word(cmd_word), .trigger_valid(trigger_valid),
    .trigger_module_ident(trig_mod), .trigger_bitstream_ident(trig_bs),
    .trigger_bitstream_size(trig_size), .opt_hw_shutdown(opts[0]),
    .opt_sw_shutdown(opts[1]), .opt_sw_startup(opts[2]), .opt_mod_reset(opts[3]),
    .hw_shutdown_done(dn[0]), .sw_shutdown_done(dn[1]), .load_done(dn[2]),
    .sw_startup_done(dn[3]), .mod_reset_done(dn[4]), .config_access_port_error(ev[0]),
    .config_access_lost(ev[1]), .fetch_error(ev[2]), .module_quiesce_ack(ack),
    .fetch_start(fetch_start), .fetch_clearing(fetch_clearing), .status(status)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    // Results that never appeared count as mismatches
    n_errors += exp_q.size() + cmd_q.size() + fs_q.size();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check_word(input string what, input logic [31:0] e, input logic [31:0] m,
                            input logic [31:0] g);
    comparisons++;
    if ((g & m) !== (e & m)) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, e & m, g & m);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic rd(input logic [1:0] b, input logic [7:0] s, input logic [31:0] e,
                    input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk);
    reg_bank <= b;
    reg_sel <= s;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    tick(2);
  endtask

  // Full compares the idents too; otherwise only bits 7:0
  task automatic expect_st(input logic shut, input logic [3:0] code, input logic [2:0] step,
                           input logic full);
    rd(2'h0, 8'h00, {cur_bs, cur_mod, shut, code, step}, full ? 32'hffff_ffff : 32'h0000_00ff);
  endtask

  task automatic wr(input logic [1:0] b, input logic [7:0] s, input logic [31:0] d,
                    input logic hit);
    if (hit) cmd_q.push_back(d);
    @(posedge clk);
    reg_bank <= b;
    reg_sel <= s;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    tick(2);
  endtask

  task automatic trig(input logic [15:0] m, input logic [7:0] b, input logic [31:0] sz,
                      input logic [3:0] o);
    @(posedge clk);
    trigger_valid <= 1'b1;
    trig_mod <= m;
    trig_bs <= b;
    trig_size <= sz;
    opts <= o;
    @(posedge clk);
    trigger_valid <= 1'b0;
    tick(2);
  endtask

  task automatic pulse(input logic [4:0] d, input logic [2:0] e);
    @(posedge clk);
    dn <= d;
    ev <= e;
    @(posedge clk);
    dn <= 5'h00;
    ev <= 3'h0;
    tick(2);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (reg_rack === 1'b1)
      check_word("reg_rdata", exp_q.size() ? exp_q.pop_front() : 'x,
                 msk_q.size() ? msk_q.pop_front() : '1, reg_rdata);
    if (cmd_valid === 1'b1)
      check_word("cmd_word", cmd_q.size() ? cmd_q.pop_front() : 'x, '1, cmd_word);
    if (fetch_start === 1'b1)
      check_word("fetch_clearing", fs_q.size() ? 32'(fs_q.pop_front()) : 'x, '1,
                 {31'h0, fetch_clearing});
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    resetn = 1'b0;
    {reg_bank, reg_sel, reg_rd, reg_wr, reg_wdata} = '0;
    {trigger_valid, trig_mod, trig_bs, trig_size, opts, dn, ev, ack} = '0;
    {cur_mod, cur_bs} = '0;
    void'($urandom(46));
    tick(20);
    resetn <= 1'b1;
    tick(1);
    expect_st(1'b0, `FAIL_NONE, `STEP_EMPTY, 1'b1);
    rd(2'h1, 8'h00, 32'h0, '1);
    rd(2'h0, 8'h01, 32'h0, '1);
    for (int i = 0; i < 6; i++) begin
      fs_q.push_back(1'b0);
      trig(16'($urandom), 8'($urandom), {16'h0, 16'($urandom)} | 32'h1, 4'h0);
      expect_st(1'b0, `FAIL_NONE, `STEP_LOAD, 1'b0);
      pulse(5'h00, ev_tab[i]);
      pulse(5'h04, 3'h0);
      expect_st(1'b0, code_tab[i], `STEP_EMPTY, 1'b0);
      expect_st(1'b0, code_tab[i], `STEP_EMPTY, 1'b0);
    end
    fs_q.push_back(1'b0);
    trig(16'($urandom), 8'($urandom), `BS_SIZE_ZERO, 4'h0);
    expect_st(1'b0, `FAIL_BAD_CONFIG, `STEP_EMPTY, 1'b0);
    cur_mod = 16'($urandom);
    cur_bs = 8'($urandom);
    fs_q.push_back(1'b0);
    trig(cur_mod, cur_bs, 32'h0000_0400, 4'h0);
    pulse(5'h04, 3'h0);
    expect_st(1'b0, `FAIL_NONE, `STEP_FULL, 1'b1);
    new_mod = 16'($urandom);
    new_bs = 8'($urandom);
    trig(new_mod, new_bs, 32'h0000_0800, 4'hf);
    expect_st(1'b0, `FAIL_NONE, `STEP_HW_SHUT, 1'b0);
    for (int i = 0; i < 6; i++) begin
      if (i == 1 || i == 2) fs_q.push_back(i == 1);
      pulse(5'h01 << done_tab[i], 3'h0);
      if (i == 5) {cur_mod, cur_bs} = {new_mod, new_bs};
      expect_st(1'b0, `FAIL_NONE, 3'(i + 2), i == 5);
    end
    wr(2'h1, 8'h00, 32'h0000_0001, 1'b0);
    wr(2'h0, 8'h01, 32'h0000_0000, 1'b0);
    wr(2'h0, 8'h00, {16'($urandom), 16'h0000}, 1'b1);
    @(posedge clk);
    ack <= 1'b1;
    expect_st(1'b1, `FAIL_NONE, `STEP_ACK_HIGH, 1'b0);
    @(posedge clk);
    ack <= 1'b0;
    expect_st(1'b1, `FAIL_NONE, `STEP_ACK_LOW, 1'b0);
    {cur_mod, cur_bs} = {16'($urandom), 8'($urandom)};
    wr(2'h0, 8'h00, {cur_mod, cur_bs, `CMD_RESTART_STATUS}, 1'b1);
    expect_st(1'b0, `FAIL_NONE, `STEP_FULL, 1'b1);
    // Replacement with no shutdown steps goes straight to the clearing load
    fs_q.push_back(1'b1);
    trig(16'($urandom), 8'($urandom), 32'h0000_0100, 4'h0);
    expect_st(1'b0, `FAIL_NONE, `STEP_CLEAR, 1'b0);
    wr(2'h0, 8'h00, 32'h0000_0000, 1'b1);
    wr(2'h0, 8'h00, 32'h0000_0001, 1'b1);
    expect_st(1'b0, `FAIL_NONE, `STEP_EMPTY, 1'b0);
    tick(4);
    summarize();
  end
endmodule // tb
